// ==== hw/csw_params.svh ====
// csw_params.svh: field layouts, reset values and timing counts
// assumes: included by bare name from design files of the clock source block
`ifndef CSW_PARAMS_SVH
`define CSW_PARAMS_SVH

// ======================================================
// clock and oscillator figures
`define CSW_REF_CLK_MHZ 100
`define CSW_INT_OSC_TYP_KHZ 240
`define CSW_INT_OSC_MIN_KHZ 120
// reference cycles per internal oscillator period, rounded down
`define CSW_INT_OSC_DIV ((`CSW_REF_CLK_MHZ * 1000) / `CSW_INT_OSC_TYP_KHZ)

// ======================================================
// stabilization select encoding and status layout
`define CSW_STAB_SEL_W 3
`define CSW_STAB_SEL_RST 3'h5
`define CSW_STAB_BITS 5
`define CSW_STAB_BASE_LOG2 11
`define CSW_STAB_CNT_W 17
`define CSW_STAB_START_W 4

// ======================================================
// cpu divider select
`define CSW_DIV_SEL_W 3
`define CSW_DIV_SEL_RST 3'h0
`define CSW_DIV_MAX_LOG2 4

`endif

// ==== hw/csw_pkg.sv ====
// csw_pkg.sv: types of the clock source and wake-up block
// assumes: compiled before every module of the block
package csw_pkg;
   // wake-up sequencer states, one-hot
   typedef enum logic [3:0] {
      CSW_RUN = 4'b0001,
      CSW_HALT = 4'b0010,
      CSW_START = 4'b0100,
      CSW_STAB = 4'b1000
   } csw_state_t;

   // cpu clock source
   typedef enum logic [1:0] {
      CSW_SRC_MAIN = 2'b00,
      CSW_SRC_SUB = 2'b01,
      CSW_SRC_INT = 2'b10
   } csw_src_t;
endpackage

// ==== hw/csw_stab_if.sv ====
// csw_stab_if.sv: carries the stabilization count between sequencer and status decode
// assumes: one clock domain, driven by csw_clock_ctrl
`timescale 1ns/10ps
interface csw_stab_if;
   logic [16:0] count;
   logic [2:0] stab_time_select;
   logic counting;
   logic [4:0] stab_status_counter;
   modport ctrl (output count, output stab_time_select, output counting,
      input stab_status_counter);
   modport stat (input count, input stab_time_select, input counting,
      output stab_status_counter);
endinterface

// ==== hw/csw_stab_status.sv ====
// csw_stab_status.sv: turns the stabilization count into sticky status bits
// assumes: ref_clk_i domain, count restarts at zero on each halt entry
`timescale 1ns/10ps
`include "csw_params.svh"
module csw_stab_status (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic halt_entry_i,
   csw_stab_if.stat stab
);
   // ======================================================
   // per-bit thresholds: 2^(11+2k)-ish steps, capped by the selected duration
   genvar k;
   generate
      for (k = 0; k < `CSW_STAB_BITS; k = k + 1) begin : g_bit
         logic bit_q;
         logic reached;
         // a bit beyond the chosen duration never rises
         assign reached = (stab.count[`CSW_STAB_BASE_LOG2 + k + (k > 0 ? k : 0) >
            16 ? 16 : `CSW_STAB_BASE_LOG2 + k + (k > 0 ? k : 0)] == 1'b1) &&
            (k <= 32'(stab.stab_time_select));
         always_ff @(posedge ref_clk_i) begin
            if (!rst_n_i || halt_entry_i) begin
               bit_q <= 1'b0;
            end else if (stab.counting && reached) begin
               bit_q <= 1'b1;
            end
         end
         assign stab.stab_status_counter[`CSW_STAB_BITS - 1 - k] = bit_q;
      end
   endgenerate
endmodule

// ==== hw/csw_clock_ctrl.sv ====
// csw_clock_ctrl.sv: cpu clock source select, divider and halt wake-up timing
// assumes: one 100 MHz reference clock; oscillator analog parts are outside
// limitation: the internal oscillator is a counter model of its typical rate
//
// Notes on behaviour
// - the stabilization count stops at the duration chosen by stab_time_select.
// - the wait excludes the time from release until the oscillator starts, for reset or irq.
// - with the internal oscillator selected the prescaler divides its 240 kHz output.
// - the internal oscillator halt bit stops it only when the option permits.
// - a divider change together with a move from subsystem to main is accepted.
// - status bits rise in order from the shortest, the two longest on one edge, and then stay set.
`timescale 1ns/10ps
`include "csw_params.svh"
module csw_clock_ctrl #(
   parameter int STAB_CNT_W = `CSW_STAB_CNT_W
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic halt_req_i,
   input wire logic wake_irq_i,
   input wire logic wake_rst_i,
   input wire logic osc_running_i,
   input wire logic main_crystal_input,
   input wire logic sub_clk_i,
   input wire logic int_osc_soft_stop_ok_i,
   input wire logic internal_osc_halt_bit_i,
   input wire logic use_int_osc_i,
   input wire logic cpu_source_select_i,
   input wire logic [2:0] cpu_divider_select_i,
   input wire logic cfg_we_i,
   input wire logic [2:0] stab_time_select_i,
   input wire logic stab_sel_we_i,
   output logic [2:0] stab_time_select_o,
   output logic [4:0] stab_status_counter_o,
   output logic [2:0] cpu_divider_select_o,
   output logic cpu_source_select_o,
   output logic int_osc_enable_o,
   output logic halted_o,
   output logic stab_done_o,
   output logic cpu_clk_en_o,
   output logic int_osc_tick_o
);
   csw_stab_if stab ();
   csw_pkg::csw_state_t state;
   csw_pkg::csw_state_t next_state;
   logic [STAB_CNT_W-1:0] cnt;
   logic [2:0] sel;
   logic [2:0] div;
   logic cpu_source_select;
   logic int_stop;
   localparam int INT_DIV_W = $clog2(`CSW_INT_OSC_DIV);
   logic [INT_DIV_W-1:0] int_div_cnt;
   logic int_tick;
   logic [`CSW_DIV_MAX_LOG2-1:0] pre_cnt;
   logic cpu_en;
   logic src_tick;
   logic [STAB_CNT_W-1:0] stab_limit;
   logic halt_entry;

   // run state decode, shared by prescaler gating, halt entry and halted flag
   function automatic logic in_run(input csw_pkg::csw_state_t s);
      in_run = (s == csw_pkg::CSW_RUN);
   endfunction

   // duration limit for the chosen select code, shortest is 2^11, then x4 a step
   // codes past the counter width saturate at all ones rather than wrapping
   function automatic logic [STAB_CNT_W-1:0] stab_len(input logic [2:0] s);
      logic [4:0] sh;
      sh = 5'(`CSW_STAB_BASE_LOG2) + 5'(2 * s);
      stab_len = (sh >= 5'(STAB_CNT_W)) ? '1 : (STAB_CNT_W)'(1) << sh;
   endfunction

   // ======================================================
   // configuration writes
   // select stands until rewritten; reset loads code 5, which already gives the longest duration
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         sel <= `CSW_STAB_SEL_RST;
      end else if (stab_sel_we_i) begin
         sel <= stab_time_select_i;
      end
   end

   // source and divider land together in one write; both directions are taken
   // no guard against a divider change on a main-to-subsystem move: that write
   // is the software's to avoid, and a guard here would also block the legal
   // reverse move that carries a new divider
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         div <= `CSW_DIV_SEL_RST;
         cpu_source_select <= 1'b0;
      end else if (cfg_we_i) begin
         div <= cpu_divider_select_i;
         cpu_source_select <= cpu_source_select_i;
      end
   end

   // internal oscillator stop honoured only with the option strap
   // registered so a strap change and a stop write take effect on one edge
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         int_stop <= 1'b0;
      end else begin
         int_stop <= internal_osc_halt_bit_i && int_osc_soft_stop_ok_i;
      end
   end

   // ======================================================
   // internal oscillator model tick at its typical rate
   // the real oscillator may run as slow as half this rate, so nothing here
   // may rely on the tick spacing for correctness
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || int_stop) begin
         int_div_cnt <= '0;
      end else if (int_div_cnt == INT_DIV_W'(`CSW_INT_OSC_DIV - 1)) begin
         int_div_cnt <= '0;
      end else begin
         int_div_cnt <= int_div_cnt + 1'b1;
      end
   end
   // tick is suppressed while stopped so no stray edge reaches the prescaler
   assign int_tick = !int_stop && (int_div_cnt == INT_DIV_W'(`CSW_INT_OSC_DIV - 1));

   // prescaler source: internal tick, subsystem or main crystal
   assign src_tick = use_int_osc_i ? int_tick :
      (cpu_source_select ? sub_clk_i : main_crystal_input);

   // ======================================================
   // prescaler: divide the source by 2^div, by 16 for any div of 4 or more
   // the count holds through halt, so the first enable after a wake may come early
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         pre_cnt <= '0;
         cpu_en <= 1'b0;
      end else begin
         cpu_en <= 1'b0;
         if (src_tick && in_run(state)) begin
            pre_cnt <= pre_cnt + 1'b1;
            cpu_en <= ((pre_cnt & ((`CSW_DIV_MAX_LOG2)'(1) << div) - 1'b1) ==
               '0) || (div == 3'h0);
         end
      end
   end

   // ======================================================
   // halt and wake-up sequencer
   // a halt request while halted, or a wake while running, is ignored
   always_comb begin
      next_state = state;
      unique case (state)
         csw_pkg::CSW_RUN: if (halt_req_i) next_state = csw_pkg::CSW_HALT;
         csw_pkg::CSW_HALT: if (wake_irq_i || wake_rst_i) next_state = csw_pkg::CSW_START;
         // wait for oscillation before timing; this gap is not part of the wait
         csw_pkg::CSW_START: if (osc_running_i) next_state = csw_pkg::CSW_STAB;
         csw_pkg::CSW_STAB: if (cnt >= stab_limit - 1'b1) next_state = csw_pkg::CSW_RUN;
         default: next_state = csw_pkg::CSW_RUN;
      endcase
   end

   // reset lands in run, so a cold start needs no wake
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         state <= csw_pkg::CSW_RUN;
      end else begin
         state <= next_state;
      end
   end

   // the limit follows the live select; software is stopped while it matters
   assign stab_limit = stab_len(sel);

   // count only while stabilising, cleared while halted, held at limit
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || state == csw_pkg::CSW_HALT) begin
         cnt <= '0;
      end else if (state == csw_pkg::CSW_STAB && cnt < stab_limit) begin
         cnt <= cnt + 1'b1;
      end
   end

   // the decoder sees the raw count and applies the select cap itself
   assign stab.count = 17'(cnt);
   assign stab.stab_time_select = sel;
   // the first halt cycle still holds the last wake's count; keep it from setting bits again
   assign stab.counting = (state == csw_pkg::CSW_STAB) || in_run(state);

   // one decode of halt entry clears the status bits on the entry edge
   assign halt_entry = in_run(state) && halt_req_i;

   // status decoder
   csw_stab_status u_status (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .halt_entry_i(halt_entry),
      .stab(stab.stat)
   );

   // ======================================================
   // outputs
   // one-cycle pulse as the wait ends, registered so it cannot glitch
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         stab_done_o <= 1'b0;
      end else begin
         stab_done_o <= (state == csw_pkg::CSW_STAB) && (next_state == csw_pkg::CSW_RUN);
      end
   end

   // readbacks come straight from their registers
   assign stab_time_select_o = sel;
   assign stab_status_counter_o = stab.stab_status_counter;
   assign cpu_divider_select_o = div;
   assign cpu_source_select_o = cpu_source_select;
   assign int_osc_enable_o = !int_stop;
   // halted covers start and stabilise too, so software sees one busy flag
   assign halted_o = !in_run(state);
   assign cpu_clk_en_o = cpu_en;
   assign int_osc_tick_o = int_tick;
endmodule

// ==== test/csw_properties.sv ====
// port checks of the clock source and wake-up block
// assumes: bound into csw_clock_ctrl, one clock, sync low reset
`timescale 1ns/10ps
module csw_properties #(
   parameter int STAB_CNT_W = 17
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic halt_req_i,
   input wire logic osc_running_i,
   input wire logic int_osc_soft_stop_ok_i,
   input wire logic internal_osc_halt_bit_i,
   input wire logic cpu_source_select_i,
   input wire logic [2:0] cpu_divider_select_i,
   input wire logic cfg_we_i,
   input wire logic [2:0] stab_time_select_o,
   input wire logic [4:0] stab_status_counter_o,
   input wire logic [2:0] cpu_divider_select_o,
   input wire logic cpu_source_select_o,
   input wire logic int_osc_enable_o,
   input wire logic halted_o
);
   // ==========================================
   // halt entry, status bits, oscillator stop, config
   default clocking dc @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   halt_clear_a: assert property (
      halt_req_i && !halted_o |=> halted_o && stab_status_counter_o == 5'h00)
      else $error("halt entry missed");
   // past reset guard: a one-edge reset would look like a lost bit
   status_sticky_a: assert property (
      $past(rst_n_i) && !(halt_req_i && !halted_o) |=>
      ($past(stab_status_counter_o) & ~stab_status_counter_o) == 5'h00)
      else $error("status bit dropped");
   status_order_a: assert property (
      (stab_status_counter_o & ~(stab_status_counter_o >> 1) & 5'h0f) == 5'h00)
      else $error("status bits out of order");
   status_cap_a: assert property (
      $changed(stab_status_counter_o) |->
      $countones(stab_status_counter_o) <= int'(stab_time_select_o) + 1)
      else $error("status beyond select");
   osc_wait_a: assert property (
      halted_o && $past(halted_o) && !osc_running_i |-> stab_status_counter_o == 5'h00)
      else $error("counting before oscillator");
   stop_blocked_a: assert property (
      !int_osc_soft_stop_ok_i && !$past(int_osc_soft_stop_ok_i) |-> int_osc_enable_o)
      else $error("stop without strap");
   stop_taken_a: assert property (
      int_osc_soft_stop_ok_i && internal_osc_halt_bit_i |-> ##[1:2] !int_osc_enable_o)
      else $error("stop ignored");
   cfg_write_a: assert property (
      cfg_we_i |=> cpu_source_select_o == $past(cpu_source_select_i) &&
      cpu_divider_select_o == $past(cpu_divider_select_i))
      else $error("config write lost");
endmodule

bind csw_clock_ctrl csw_properties #(.STAB_CNT_W(STAB_CNT_W)) i_props (.ref_clk_i, .rst_n_i,
   .halt_req_i, .osc_running_i, .int_osc_soft_stop_ok_i, .internal_osc_halt_bit_i,
   .cpu_source_select_i, .cpu_divider_select_i, .cfg_we_i, .stab_time_select_o,
   .stab_status_counter_o, .cpu_divider_select_o, .cpu_source_select_o, .int_osc_enable_o,
   .halted_o);

// ==== test/tb_top.sv ====
// self-checking bench of the clock source and wake-up block
// assumes: design and checker compiled first; 100 MHz clock
`timescale 1ns/10ps
module tb_top;
   logic ref_clk_i = 1'b0;
   logic rst_n_i, halt_req_i, wake_irq_i, wake_rst_i, osc_running_i, main_crystal_input;
   logic sub_clk_i, int_osc_soft_stop_ok_i, internal_osc_halt_bit_i, use_int_osc_i;
   logic cpu_source_select_i, cfg_we_i, stab_sel_we_i, cpu_source_select_o, int_osc_enable_o;
   logic halted_o, stab_done_o, cpu_clk_en_o, int_osc_tick_o;
   logic [2:0] cpu_divider_select_i, stab_time_select_i, stab_time_select_o, cpu_divider_select_o;
   logic [4:0] stab_status_counter_o;
   int errors = 0;
   int check_count = 0;
   int n;
   // rows of {source, divider}; the outputs must give the row back
   // no row changes the divider on a main-to-subsystem move
   logic [3:0] rows [5] = '{4'h8, 4'h3, 4'hb, 4'h6, 4'h2};

   csw_clock_ctrl i_dut (.ref_clk_i, .rst_n_i, .halt_req_i, .wake_irq_i, .wake_rst_i,
      .osc_running_i, .main_crystal_input, .sub_clk_i, .int_osc_soft_stop_ok_i,
      .internal_osc_halt_bit_i, .use_int_osc_i, .cpu_source_select_i, .cpu_divider_select_i,
      .cfg_we_i, .stab_time_select_i, .stab_sel_we_i, .stab_time_select_o,
      .stab_status_counter_o, .cpu_divider_select_o, .cpu_source_select_o, .int_osc_enable_o,
      .halted_o, .stab_done_o, .cpu_clk_en_o, .int_osc_tick_o);

   // ==========================================
   // clock, compare and wait helpers
   always #5 ref_clk_i = ~ref_clk_i;

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // bounded wait on stab_done_o (on_done) or the oscillator tick, sampled 1 ns
   // after each edge so updates have landed
   task automatic await(input bit on_done);
      n = 0;
      do begin
         @(posedge ref_clk_i);
         #1 n++;
      end while ((on_done ? stab_done_o : int_osc_tick_o) !== 1'b1 && n < 20000);
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // one halt and wake-up; the oscillator start is held back 50 cycles
   task automatic wake(input logic [2:0] s, input logic by_irq, input logic [4:0] exp_st);
      int e;
      e = 1 << (11 + 2 * s);
      @(posedge ref_clk_i);
      stab_time_select_i <= s;
      stab_sel_we_i <= 1'b1;
      @(posedge ref_clk_i);
      stab_sel_we_i <= 1'b0;
      halt_req_i <= 1'b1;
      @(posedge ref_clk_i);
      halt_req_i <= 1'b0;
      wake_irq_i <= by_irq;
      wake_rst_i <= !by_irq;
      repeat (50) @(posedge ref_clk_i);
      #1 chk({halted_o, stab_status_counter_o}, 16'h0020);
      @(posedge ref_clk_i);
      osc_running_i <= 1'b1;
      await(1'b1);
      chk(16'(n >= e - 2 && n <= e + 10), 16'h0001);
      repeat (3) @(posedge ref_clk_i);
      #1 chk({halted_o, stab_status_counter_o}, {11'h000, exp_st});
      @(posedge ref_clk_i);
      {wake_irq_i, wake_rst_i, osc_running_i} <= 3'h0;
      $display("wake test done, select %0d", s);
   endtask

   // ==========================================
   // main sequence
   initial begin
      {rst_n_i, halt_req_i, wake_irq_i, wake_rst_i, osc_running_i, main_crystal_input} = '0;
      {sub_clk_i, int_osc_soft_stop_ok_i, internal_osc_halt_bit_i, cfg_we_i} = '0;
      {stab_sel_we_i, use_int_osc_i, cpu_source_select_i} = '0;
      {cpu_divider_select_i, stab_time_select_i} = '0;
      repeat (5) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      #1 chk({stab_time_select_o, cpu_divider_select_o, cpu_source_select_o,
         stab_status_counter_o, halted_o, int_osc_enable_o}, 16'h2801);
      $display("reset test done");
      foreach (rows[i]) begin
         @(posedge ref_clk_i);
         {cpu_source_select_i, cpu_divider_select_i} <= rows[i];
         cfg_we_i <= 1'b1;
         @(posedge ref_clk_i);
         cfg_we_i <= 1'b0;
         #1 chk({cpu_source_select_o, cpu_divider_select_o}, rows[i]);
      end
      $display("config test done");
      // divider 2 on a crystal that ticks every cycle: one enable in four
      @(posedge ref_clk_i);
      main_crystal_input <= 1'b1;
      n = 0;
      repeat (16) begin
         @(posedge ref_clk_i);
         #1 n += (cpu_clk_en_o === 1'b1);
      end
      chk(16'(n), 16'h0004);
      // subsystem ticks must not reach the prescaler while main is selected
      @(posedge ref_clk_i);
      {main_crystal_input, sub_clk_i} <= 2'b01;
      n = 0;
      repeat (16) begin
         @(posedge ref_clk_i);
         #1 n += (cpu_clk_en_o === 1'b1);
      end
      chk(16'(n), 16'h0000);
      @(posedge ref_clk_i);
      sub_clk_i <= 1'b0;
      $display("prescaler test done");
      @(posedge ref_clk_i);
      internal_osc_halt_bit_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      #1 chk(int_osc_enable_o, 1'b1);
      @(posedge ref_clk_i);
      int_osc_soft_stop_ok_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      #1 chk(int_osc_enable_o, 1'b0);
      @(posedge ref_clk_i);
      internal_osc_halt_bit_i <= 1'b0;
      use_int_osc_i <= 1'b1;
      // the 20000-cycle bound covers even a 120 kHz worst-case period
      await(1'b0);
      await(1'b0);
      chk(16'(n), 16'h01a0);
      $display("oscillator test done");
      wake(3'h0, 1'b1, 5'h10);
      wake(3'h1, 1'b0, 5'h18);
      finish_test();
   end

   // hang guard, well past the two wake-ups of about 11000 cycles
   initial begin
      repeat (30000) @(posedge ref_clk_i);
      errors++;
      finish_test();
   end
endmodule
